// [hdl/usbia_top.sv]
// Notes on behaviour
// - Valid start-of-frame packet sets status bit 7.
// - Late-frame point, ten clocks before next frame, sets status bit 6.
// - USB registers bits 5 and 4 read zero.
// - Received OUT packet sets endpoint flag; hub ep0 bit 3, function eps bits 2..0.
// - Transmit ready cleared with transmit complete set sets endpoint flag.
// - Setup packet received sets the flag, control endpoints only.
// - Any transmit-complete set also sets the endpoint flag.
// - USB mask bit one masks its interrupt; masks reset to zero.
// - USB enable bit one enables its interrupt; resets to zero.
// - Writing one to acknowledge clears that USB flag only; zero does nothing.
// - Remote wakeup from external interrupt 1 sets suspend/resume bit 2.
// - Resume on any hub port except port 1 sets bit 1.
// - Global suspend signaling sets bit 0.
// - Suspend/resume flag with both its enable and its mask bit set raises an interrupt.
// - Suspend/resume mask one shows enabled event, zero hides it.
// - Suspend/resume registers bits 7..3 read zero.
// - Suspend/resume flags clear by writing zero to their own bit.
//
// The strobed register port is this design's own decision.
`include "usbia_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module usbia_top #(
	parameter int N_PORTS = 3
) (
	input  wire logic                  MCLK,
	input  wire logic                  RST_N,
	input  wire logic [12:0]           ADDR,
	input  wire logic [7:0]            WDATA,
	input  wire logic                  WR,
	input  wire logic                  RD,
	output logic      [7:0]            RDATA,
	input  wire logic                  SOF_VALID,
	input  wire logic                  LATE_FRAME_POINT,
	input  wire logic [3:0]            EP_IS_CTRL,
	input  wire logic [3:0]            EP_RX_OUT_SET,
	input  wire logic [3:0]            EP_TX_READY_CLR,
	input  wire logic [3:0]            EP_TX_COMPLETE_SET,
	input  wire logic [3:0]            EP_RX_SETUP_SET,
	input  wire logic                  EXT_INT1_WAKEUP,
	input  wire logic [N_PORTS-1:0]    PORT_RESUME,
	input  wire logic                  GLOBAL_SUSPEND,
	output logic                       USB_IRQ,
	output logic                       SR_IRQ
);

	// Port 1 is always excluded, so fewer than two ports leaves nothing to watch
	generate
		if (N_PORTS < 2) begin : g_bad_ports
			$error("N_PORTS must be at least 2");
		end
	endgenerate

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	usbia_pkg::usbia_byte_t usb_irq_status;
	usbia_pkg::usbia_byte_t usb_irq_enable;
	usbia_pkg::usbia_byte_t usb_irq_mask;
	usbia_pkg::usbia_byte_t suspend_resume_status;
	usbia_pkg::usbia_byte_t suspend_resume_enable;
	usbia_pkg::usbia_byte_t suspend_resume_mask;
	usbia_pkg::usbia_byte_t next_usb_irq_status;
	usbia_pkg::usbia_byte_t next_sr_status;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	function automatic logic hit(input logic [12:0] a, input logic [12:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	wire logic wr_enable  = WR && hit(ADDR, `USBIA_OFS_IRQ_ENABLE);
	wire logic wr_ack     = WR && hit(ADDR, `USBIA_OFS_IRQ_ACK);
	wire logic wr_mask    = WR && hit(ADDR, `USBIA_OFS_IRQ_MASK);
	wire logic wr_sr_en   = WR && hit(ADDR, `USBIA_OFS_SR_ENABLE);
	wire logic wr_sr_stat = WR && hit(ADDR, `USBIA_OFS_SR_STATUS);
	wire logic wr_sr_mask = WR && hit(ADDR, `USBIA_OFS_SR_MASK);

	// ------------------------------------------------------------
	// Event capture
	// ------------------------------------------------------------
	// Endpoint order in the vector: 3 hub ep0, 2..0 function eps
	logic [3:0] ep_event;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_ep
			assign ep_event[gi] = EP_RX_OUT_SET[gi]
				| (EP_TX_READY_CLR[gi] & EP_TX_COMPLETE_SET[gi])
				| (EP_RX_SETUP_SET[gi] & EP_IS_CTRL[gi])
				| EP_TX_COMPLETE_SET[gi];
		end
	endgenerate

	// The late-frame input is the frame timer's point, already placed ten clocks early
	wire logic [7:0] usb_set = {SOF_VALID,
		LATE_FRAME_POINT,
		2'b00, ep_event} & `USBIA_USB_IMPL;

	wire logic resume_other = |PORT_RESUME[N_PORTS-1:1];
	wire logic [7:0] sr_set = {5'b00000, EXT_INT1_WAKEUP,
		resume_other, GLOBAL_SUSPEND};

	wire logic [7:0] usb_clr = wr_ack ? WDATA : 8'h00;
	wire logic [7:0] sr_clr  = wr_sr_stat ? ~WDATA : 8'h00;

	// Set beats clear so an event in the clear cycle survives
	assign next_usb_irq_status = ((usb_irq_status & ~usb_clr) | usb_set)
		& `USBIA_USB_IMPL;
	assign next_sr_status = ((suspend_resume_status & ~sr_clr) | sr_set)
		& `USBIA_SR_IMPL;

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			usb_irq_status        <= `USBIA_RESET_VAL;
			usb_irq_enable        <= `USBIA_RESET_VAL;
			usb_irq_mask          <= `USBIA_RESET_VAL;
			suspend_resume_status <= `USBIA_RESET_VAL;
			suspend_resume_enable <= `USBIA_RESET_VAL;
			suspend_resume_mask   <= `USBIA_RESET_VAL;
		end else begin
			usb_irq_status        <= next_usb_irq_status;
			suspend_resume_status <= next_sr_status;
			if (wr_enable)
				usb_irq_enable <= WDATA & `USBIA_USB_IMPL;
			if (wr_mask)
				usb_irq_mask <= WDATA & `USBIA_USB_IMPL;
			if (wr_sr_en)
				suspend_resume_enable <= WDATA & `USBIA_SR_IMPL;
			if (wr_sr_mask)
				suspend_resume_mask <= WDATA & `USBIA_SR_IMPL;
		end
	end

	// ------------------------------------------------------------
	// Interrupt requests
	// ------------------------------------------------------------
	// USB mask one hides; suspend/resume mask one shows: opposite senses
	wire logic usb_req = |(usb_irq_status & usb_irq_enable & ~usb_irq_mask);
	wire logic sr_req  = |(suspend_resume_status & suspend_resume_enable
		& suspend_resume_mask);

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	usbia_pkg::usbia_byte_t rd_mux;
	always_comb begin
		unique case (ADDR)
			`USBIA_OFS_IRQ_ENABLE: rd_mux = usb_irq_enable;
			`USBIA_OFS_IRQ_MASK:   rd_mux = usb_irq_mask;
			`USBIA_OFS_IRQ_STATUS: rd_mux = usb_irq_status;
			`USBIA_OFS_SR_ENABLE:  rd_mux = suspend_resume_enable;
			`USBIA_OFS_SR_STATUS:  rd_mux = suspend_resume_status;
			`USBIA_OFS_SR_MASK:    rd_mux = suspend_resume_mask;
			default:               rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			RDATA   <= 8'h00;
			USB_IRQ <= 1'b0;
			SR_IRQ  <= 1'b0;
		end else begin
			RDATA   <= RD ? rd_mux : 8'h00;
			USB_IRQ <= usb_req;
			SR_IRQ  <= sr_req;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_sof_sets: assert property (@(posedge MCLK) disable iff (!RST_N)
		SOF_VALID |=> usb_irq_status[7]) else $error("frame start flag not set");
	chk_late_sets: assert property (@(posedge MCLK) disable iff (!RST_N)
		LATE_FRAME_POINT |=> usb_irq_status[6]) else $error("late frame flag not set");
	chk_usb_resv: assert property (@(posedge MCLK) disable iff (!RST_N)
		RD |=> RDATA[5:4] == 2'b00) else $error("reserved usb bits nonzero");
	chk_ep_out_sets: assert property (@(posedge MCLK) disable iff (!RST_N)
		EP_RX_OUT_SET[3] |=> usb_irq_status[3]) else $error("hub ep flag not set");
	chk_ack_clears: assert property (@(posedge MCLK) disable iff (!RST_N)
		wr_ack && WDATA[0] && !usb_set[0] |=> !usb_irq_status[0])
		else $error("ack did not clear");
	chk_ack_zero_keeps: assert property (@(posedge MCLK) disable iff (!RST_N)
		wr_ack && !WDATA[7] && usb_irq_status[7] |=> usb_irq_status[7])
		else $error("ack zero cleared flag");
	chk_set_wins: assert property (@(posedge MCLK) disable iff (!RST_N)
		wr_ack && WDATA[7] && SOF_VALID |=> usb_irq_status[7])
		else $error("set lost to clear");
	chk_sr_clear: assert property (@(posedge MCLK) disable iff (!RST_N)
		wr_sr_stat && !WDATA[0] && !GLOBAL_SUSPEND |=> !suspend_resume_status[0])
		else $error("suspend flag not cleared");
	chk_sr_irq: assert property (@(posedge MCLK) disable iff (!RST_N)
		sr_req |=> SR_IRQ) else $error("suspend resume irq missing");
	chk_usb_masked: assert property (@(posedge MCLK) disable iff (!RST_N)
		(usb_irq_mask == `USBIA_USB_IMPL) && $stable(usb_irq_mask) |=> !USB_IRQ)
		else $error("masked irq visible");
	chk_resume_port1: assert property (@(posedge MCLK) disable iff (!RST_N)
		!suspend_resume_status[1] && PORT_RESUME == N_PORTS'(1) && !wr_sr_stat
		|=> !suspend_resume_status[1]) else $error("port 1 resume counted");
	chk_tx_done_sets: assert property (@(posedge MCLK) disable iff (!RST_N)
		EP_TX_COMPLETE_SET[1] |=> usb_irq_status[1]) else $error("tx done flag not set");
	chk_tx_pair_sets: assert property (@(posedge MCLK) disable iff (!RST_N)
		EP_TX_READY_CLR[2] && EP_TX_COMPLETE_SET[2] |=> usb_irq_status[2])
		else $error("tx pair flag not set");
	chk_setup_ctrl: assert property (@(posedge MCLK) disable iff (!RST_N)
		EP_RX_SETUP_SET[0] && EP_IS_CTRL[0] |=> usb_irq_status[0])
		else $error("setup flag not set");
	chk_wake_sets: assert property (@(posedge MCLK) disable iff (!RST_N)
		EXT_INT1_WAKEUP |=> suspend_resume_status[2]) else $error("wakeup flag not set");
	chk_suspend_sets: assert property (@(posedge MCLK) disable iff (!RST_N)
		GLOBAL_SUSPEND |=> suspend_resume_status[0]) else $error("suspend flag not set");
	chk_sr_resv: assert property (@(posedge MCLK) disable iff (!RST_N)
		suspend_resume_status[7:3] == 5'h00 && suspend_resume_mask[7:3] == 5'h00)
		else $error("reserved sr bits nonzero");
	chk_sr_hidden: assert property (@(posedge MCLK) disable iff (!RST_N)
		suspend_resume_mask == 8'h00 && $stable(suspend_resume_mask) |=> !SR_IRQ)
		else $error("hidden sr irq visible");
	chk_usb_irq: assert property (@(posedge MCLK) disable iff (!RST_N)
		usb_req |=> USB_IRQ) else $error("usb irq missing");
	chk_enable_off: assert property (@(posedge MCLK) disable iff (!RST_N)
		usb_irq_enable == 8'h00 && $stable(usb_irq_enable) |=> !USB_IRQ)
		else $error("disabled irq visible");

endmodule : usbia_top

`default_nettype wire

// [include/usbia_cfg.svh]
`ifndef USBIA_CFG_SVH
`define USBIA_CFG_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define USBIA_OFS_IRQ_ENABLE  13'h1FF3
`define USBIA_OFS_IRQ_ACK     13'h1FF5
`define USBIA_OFS_IRQ_MASK    13'h1FF6
`define USBIA_OFS_IRQ_STATUS  13'h1FF7
`define USBIA_OFS_SR_ENABLE   13'h1FF9
`define USBIA_OFS_SR_STATUS   13'h1FFA
`define USBIA_OFS_SR_MASK     13'h1FFB

// ------------------------------------------------------------
// Field positions and masks
// ------------------------------------------------------------
`define USBIA_BIT_FRAME_START 7
`define USBIA_BIT_LATE_FRAME  6
`define USBIA_BIT_HUB_EP0     3
`define USBIA_USB_IMPL        8'hCF
`define USBIA_BIT_WAKEUP      2
`define USBIA_BIT_RESUME      1
`define USBIA_BIT_SUSPEND     0
`define USBIA_SR_IMPL         8'h07
`define USBIA_RESET_VAL       8'h00

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define USBIA_LATE_FRAME_LEAD 10

`endif

// [include/usbia_pkg.sv]
package usbia_pkg;
	typedef logic [7:0]  usbia_byte_t;
	typedef logic [12:0] usbia_addr_t;
endpackage : usbia_pkg

// [verif/usbia_engine_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// Engine side: one-cycle event pulses a clock after the request
// ------------------------------------------------------------
module usbia_engine_model (
	input  wire logic       clk,
	input  wire logic [3:0] ev,
	input  wire logic [3:0] sel,
	output logic            sof,
	output logic            late,
	output logic [3:0]      ep_ctrl,
	output logic [3:0]      rx_out,
	output logic [3:0]      tx_rdy_clr,
	output logic [3:0]      tx_done,
	output logic [3:0]      rx_setup,
	output logic            wake,
	output logic [2:0]      resume,
	output logic            suspend
);
	// Hub ep0 and function ep0 are the control endpoints
	assign ep_ctrl = 4'h9;
	initial {sof, late, rx_out, tx_rdy_clr, tx_done, rx_setup, wake, resume, suspend} = '0;
	always @(posedge clk) begin
		sof        <= (ev == 4'h1);
		late       <= (ev == 4'h2);
		rx_out     <= (ev == 4'h3) ? sel : 4'h0;
		tx_rdy_clr <= (ev == 4'h4) ? sel : 4'h0;
		tx_done    <= (ev == 4'h4 || ev == 4'h6) ? sel : 4'h0;
		rx_setup   <= (ev == 4'h5) ? sel : 4'h0;
		wake       <= (ev == 4'h7);
		resume     <= (ev == 4'h8) ? sel[2:0] : 3'h0;
		suspend    <= (ev == 4'h9);
	end
endmodule : usbia_engine_model
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
`include "usbia_cfg.svh"
module testbench;
	typedef struct packed {logic [3:0] ev; logic [3:0] sel; logic [12:0] a; logic [7:0] v;} usbia_row_t;
	localparam usbia_row_t ROWS [13] = '{
		'{4'h1, 4'h0, `USBIA_OFS_IRQ_STATUS, 8'h80}, '{4'h2, 4'h0, `USBIA_OFS_IRQ_STATUS, 8'h40},
		'{4'h3, 4'h8, `USBIA_OFS_IRQ_STATUS, 8'h08}, '{4'h3, 4'h4, `USBIA_OFS_IRQ_STATUS, 8'h04},
		'{4'h4, 4'h2, `USBIA_OFS_IRQ_STATUS, 8'h02}, '{4'h5, 4'h1, `USBIA_OFS_IRQ_STATUS, 8'h01},
		'{4'h5, 4'h2, `USBIA_OFS_IRQ_STATUS, 8'h00}, '{4'h6, 4'h8, `USBIA_OFS_IRQ_STATUS, 8'h08},
		'{4'h7, 4'h0, `USBIA_OFS_SR_STATUS, 8'h04}, '{4'h8, 4'h1, `USBIA_OFS_SR_STATUS, 8'h00},
		'{4'h8, 4'h2, `USBIA_OFS_SR_STATUS, 8'h02}, '{4'h8, 4'h4, `USBIA_OFS_SR_STATUS, 8'h02},
		'{4'h9, 4'h0, `USBIA_OFS_SR_STATUS, 8'h01}};
	logic                   mclk  = 1'b0;
	logic                   rst_n = 1'b0;
	logic                   wr_s  = 1'b0;
	logic                   rd_s  = 1'b0;
	usbia_pkg::usbia_addr_t addr  = 13'h0000;
	usbia_pkg::usbia_byte_t wdata = 8'h00;
	usbia_pkg::usbia_byte_t rdata;
	logic                   usb_irq, sr_irq, sof, late, wake, suspend;
	logic [3:0]             ev = 4'h0;
	logic [3:0]             sel = 4'h0;
	logic [3:0]             ep_ctrl, rx_out, tx_rdy_clr, tx_done, rx_setup;
	logic [2:0]             resume;
	int                     errors = 0;
	int                     checked = 0;
	always #5 mclk = ~mclk;
	usbia_engine_model i_engine (.clk(mclk), .ev(ev), .sel(sel), .sof(sof), .late(late),
		.ep_ctrl(ep_ctrl), .rx_out(rx_out), .tx_rdy_clr(tx_rdy_clr), .tx_done(tx_done),
		.rx_setup(rx_setup), .wake(wake), .resume(resume), .suspend(suspend));
	usbia_top #(.N_PORTS(3)) i_dut (.MCLK(mclk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
		.WR(wr_s), .RD(rd_s), .RDATA(rdata), .SOF_VALID(sof), .LATE_FRAME_POINT(late),
		.EP_IS_CTRL(ep_ctrl), .EP_RX_OUT_SET(rx_out), .EP_TX_READY_CLR(tx_rdy_clr),
		.EP_TX_COMPLETE_SET(tx_done), .EP_RX_SETUP_SET(rx_setup), .EXT_INT1_WAKEUP(wake),
		.PORT_RESUME(resume), .GLOBAL_SUSPEND(suspend), .USB_IRQ(usb_irq), .SR_IRQ(sr_irq));
	task automatic chk(input usbia_pkg::usbia_byte_t got, input usbia_pkg::usbia_byte_t exp);
		checked++;
		if (got !== exp) begin
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
			errors++;
		end
	endtask : chk
	task automatic wr(input usbia_pkg::usbia_addr_t a, input usbia_pkg::usbia_byte_t v);
		wr_s <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge mclk);
		wr_s <= 1'b0;
		@(posedge mclk);
	endtask : wr
	task automatic rd(input usbia_pkg::usbia_addr_t a, input usbia_pkg::usbia_byte_t exp);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd_s <= 1'b0;
		#1 chk(rdata, exp);
		@(posedge mclk);
	endtask : rd
	task automatic fire(input logic [3:0] e, input logic [3:0] s);
		ev <= e;
		sel <= s;
		@(posedge mclk);
		ev <= 4'h0;
		repeat (3) @(posedge mclk);
	endtask : fire
	// Settle margin of two cycles covers the registered request
	task automatic irq(input logic u, input logic s);
		repeat (2) @(posedge mclk);
		#1 chk({6'h00, usb_irq, sr_irq}, {6'h00, u, s});
		@(posedge mclk);
	endtask : irq
	task automatic results;
		if (errors == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results
	initial begin
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		for (int a = 13'h1FF3; a <= 13'h1FFB; a++) rd(13'(a), 8'h00);
		wr(`USBIA_OFS_IRQ_ENABLE, 8'hFF);
		wr(`USBIA_OFS_IRQ_MASK, 8'hFF);
		wr(`USBIA_OFS_SR_ENABLE, 8'hFF);
		wr(`USBIA_OFS_SR_MASK, 8'hFF);
		wr(13'h0000, 8'hFF);
		rd(`USBIA_OFS_IRQ_ENABLE, 8'hCF);
		rd(`USBIA_OFS_IRQ_MASK, 8'hCF);
		rd(`USBIA_OFS_SR_ENABLE, 8'h07);
		rd(`USBIA_OFS_SR_MASK, 8'h07);
		rd(13'h0000, 8'h00);
		foreach (ROWS[i]) begin
			fire(ROWS[i].ev, ROWS[i].sel);
			rd(ROWS[i].a, ROWS[i].v);
			wr(`USBIA_OFS_IRQ_ACK, 8'hFF);
			wr(`USBIA_OFS_SR_STATUS, 8'h00);
		end
		wr(`USBIA_OFS_IRQ_ENABLE, 8'h80);
		wr(`USBIA_OFS_IRQ_MASK, 8'h00);
		fire(4'h1, 4'h0);
		irq(1'b1, 1'b0);
		wr(`USBIA_OFS_IRQ_MASK, 8'h80);
		irq(1'b0, 1'b0);
		wr(`USBIA_OFS_IRQ_MASK, 8'h00);
		wr(`USBIA_OFS_IRQ_ACK, 8'h4F);
		rd(`USBIA_OFS_IRQ_STATUS, 8'h80);
		wr(`USBIA_OFS_IRQ_ACK, 8'h80);
		rd(`USBIA_OFS_IRQ_STATUS, 8'h00);
		irq(1'b0, 1'b0);
		fire(4'h2, 4'h0);
		irq(1'b0, 1'b0);
		wr(`USBIA_OFS_SR_MASK, 8'h00);
		wr(`USBIA_OFS_SR_ENABLE, 8'h01);
		fire(4'h9, 4'h0);
		irq(1'b0, 1'b0);
		wr(`USBIA_OFS_SR_MASK, 8'h07);
		irq(1'b0, 1'b1);
		wr(`USBIA_OFS_SR_STATUS, 8'h01);
		rd(`USBIA_OFS_SR_STATUS, 8'h01);
		wr(`USBIA_OFS_SR_STATUS, 8'h00);
		irq(1'b0, 1'b0);
		fire(4'h8, 4'h2);
		irq(1'b0, 1'b0);
		// Event and clear land on the same edge
		ev <= 4'h1;
		@(posedge mclk);
		ev <= 4'h0;
		wr(`USBIA_OFS_IRQ_ACK, 8'hC0);
		rd(`USBIA_OFS_IRQ_STATUS, 8'h80);
		ev <= 4'h9;
		@(posedge mclk);
		ev <= 4'h0;
		wr(`USBIA_OFS_SR_STATUS, 8'h00);
		rd(`USBIA_OFS_SR_STATUS, 8'h01);
		// Reset in mid-run must clear flags and settings
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		rd(`USBIA_OFS_SR_STATUS, 8'h00);
		rd(`USBIA_OFS_IRQ_STATUS, 8'h00);
		rd(`USBIA_OFS_IRQ_MASK, 8'h00);
		rd(`USBIA_OFS_IRQ_ENABLE, 8'h00);
		irq(1'b0, 1'b0);
		results();
	end
endmodule : testbench
`default_nettype wire
